// ---- hdl/siu_core.sv ----
// System integration unit: priority, break, low-power and status logic.
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps

// Behaviour
// - Fixed priority: reset, software interrupt, then sources.
// - Status one: flags 6..1 in bits 7..2.
// - Status two: flags 14..7, read-only.
// - Status three: flags 16..15 low, rest zero.
// - Flag reads one while request present.
// - Resets bypass interrupt arbitration entirely.
// - Break request forces software-interrupt vector.
// - Break clears allowed only with clear enable.
// - Flag cleared in break stays cleared.
// - Two-step clear protected in break.
// - Low-power entry stops CPU, clears mask.
// - Wait: peripherals run; stack one cycle later.
// - Watchdog keeps counting in wait unless disabled.
// - Stop holds counter, gates clocks, oscillator unless keep option set.
// - Stop exit waits 4096 or 32 cycles.
// - Stacking waits for full stop recovery.
// - Reset ending stop uses long recovery.
// - Counter cleared in stop, counts recovery.
// - Break-exit flag shows break ended wait.
// - Reading reset-source register clears flags.
// - Separate flags for each reset cause.
module siu_core (
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	input  wire logic        clk_en_in,
	input  wire logic [15:0] reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_write_in,
	input  wire logic        reg_read_in,
	output logic      [7:0]  reg_rdata_out,
	input  wire logic [16:1] irq_req_in,
	input  wire logic [16:1] irq_enable_in,
	input  wire logic        cpu_imask_in,
	input  wire logic        swi_exec_in,
	input  wire logic        break_req_in,
	input  wire logic        break_done_in,
	input  wire logic        wait_exec_in,
	input  wire logic        stop_exec_in,
	input  wire logic        xtal_tick_in,
	input  wire logic        short_stop_recovery_in,
	input  wire logic        stop_oscillator_keep_in,
	input  wire logic        watchdog_disable_in,
	input  wire logic        por_event_in,
	input  wire logic        pin_reset_in,
	input  wire logic        watchdog_reset_in,
	input  wire logic        bad_opcode_in,
	input  wire logic        bad_fetch_address_in,
	input  wire logic        forced_monitor_in,
	input  wire logic        low_voltage_in,
	input  wire logic        flag_clear_req_in,
	output logic             flag_clear_ok_out,
	output logic             reset_active_out,
	output logic             irq_take_out,
	output logic      [4:0]  vector_sel_out,
	output logic             cpu_clk_en_out,
	output logic             periph_clk_en_out,
	output logic             osc_en_out,
	output logic             watchdog_run_out,
	output logic             clear_imask_out,
	output logic             break_state_out,
	output logic      [12:0] recovery_count_out
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	siu_pkg::siu_lp_e state_r;
	siu_pkg::siu_lp_e state_nxt;
	logic [7:0]  rsrc_r;
	logic [7:0]  rsrc_nxt;
	logic        break_clear_enable_r;
	logic        bexit_r;
	logic        bexit_nxt;
	logic        brk_r;
	logic [12:0] cnt_r;
	logic [12:0] cnt_nxt;
	logic [12:0] limit_r;
	logic [12:0] limit_nxt;
	logic        rec_reset_r;
	logic        take_r;
	logic [4:0]  vec_r;
	logic [7:0]  rdata_r;
	logic [16:1] active;
	logic [4:0]  win_idx;
	logic        any_irq;
	logic        any_reset;
	logic        wake;
	logic        rec_done;
	logic        sel_bstat;
	logic        sel_rsrc;
	logic        sel_bfc;
	logic        sel_one;
	logic        sel_two;
	logic        sel_three;
	logic [7:0]  rd_mux;
	logic [7:0]  st_one;
	logic [7:0]  st_two;
	logic [7:0]  st_three;
	logic [7:0]  rsrc_set;

	// ------------------------------------------------------------
	// Live status bytes
	// ------------------------------------------------------------
	// Flags follow the request lines directly, so a debug read
	// never disturbs what the arbiter sees.
	assign st_one   = {irq_req_in[6:1], 2'b00};
	assign st_two   = irq_req_in[14:7];
	assign st_three = {6'h00, irq_req_in[16:15]};

	// ------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------
	// A source may win only if enabled and the mask is clear.
	assign active = irq_req_in & irq_enable_in & {16{~cpu_imask_in}};
	assign any_irq = |active;
	assign any_reset = por_event_in | pin_reset_in | watchdog_reset_in |
		bad_opcode_in | bad_fetch_address_in | forced_monitor_in |
		low_voltage_in;

	// Lowest index wins; index 1 is the external pin source.
	always_comb begin
		win_idx = 5'h00;
		for (int i = siu_pkg::NUM_SOURCES; i >= 1; i--) begin
			if (active[i]) begin
				win_idx = 5'(i + 1);
			end
		end
	end

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	assign sel_bstat = reg_addr_in == siu_pkg::BREAK_STATUS_OFS;
	assign sel_rsrc  = reg_addr_in == siu_pkg::RESET_SOURCE_OFS;
	assign sel_bfc   = reg_addr_in == siu_pkg::BREAK_FLAG_CTRL_OFS;
	assign sel_one   = reg_addr_in == siu_pkg::IRQ_STATUS_ONE_OFS;
	assign sel_two   = reg_addr_in == siu_pkg::IRQ_STATUS_TWO_OFS;
	assign sel_three = reg_addr_in == siu_pkg::IRQ_STATUS_THREE_OFS;
	// Unmapped addresses read as zero.
	assign rd_mux =
		sel_bstat ? {6'h00, bexit_r, 1'b0} :
		sel_rsrc  ? rsrc_r :
		sel_bfc   ? {break_clear_enable_r, 7'h00} :
		sel_one   ? st_one :
		sel_two   ? st_two :
		sel_three ? st_three : siu_pkg::BYTE_ZERO;

	// ------------------------------------------------------------
	// Reset-source flags
	// ------------------------------------------------------------
	assign rsrc_set = {1'b0, pin_reset_in, watchdog_reset_in, bad_opcode_in,
		bad_fetch_address_in, forced_monitor_in, 1'b0,
		low_voltage_in};
	// Power-on wipes the rest; other causes only add, and a cause
	// landing with a read survives the clear.
	assign rsrc_nxt = por_event_in ? siu_pkg::RSRC_RESET_VAL :
		(((reg_read_in && sel_rsrc) ? siu_pkg::BYTE_ZERO :
		rsrc_r) | rsrc_set);

	// ------------------------------------------------------------
	// Break handling
	// ------------------------------------------------------------
	// Clears elsewhere pass only outside break or with enable set;
	// a second step held back in break simply retries later.
	assign flag_clear_ok_out = flag_clear_req_in &
		(~brk_r | break_clear_enable_r);
	assign break_state_out = brk_r;
	// Set when break wakes the core from wait; cleared on a read.
	assign bexit_nxt = (break_req_in && state_r == siu_pkg::SIU_WAIT) ? 1'b1 :
		(reg_read_in && sel_bstat) ? 1'b0 : bexit_r;

	// ------------------------------------------------------------
	// Low-power sequencing
	// ------------------------------------------------------------
	assign wake = any_irq | break_req_in;
	assign rec_done = cnt_r >= limit_r;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		limit_nxt = limit_r;
		unique case (state_r)
			siu_pkg::SIU_RUN: begin
				if (stop_exec_in) begin
					state_nxt = siu_pkg::SIU_STOP;
				end else if (wait_exec_in) begin
					state_nxt = siu_pkg::SIU_WAIT;
				end
			end
			siu_pkg::SIU_WAIT: begin
				if (wake) begin
					state_nxt = siu_pkg::SIU_RUN;
				end
			end
			siu_pkg::SIU_STOP: begin
				cnt_nxt = 13'h0000;
				if (wake) begin
					state_nxt = siu_pkg::SIU_RECOVER;
					limit_nxt = short_stop_recovery_in ?
						siu_pkg::SHORT_RECOVERY_CYC :
						siu_pkg::LONG_RECOVERY_CYC;
				end
			end
			siu_pkg::SIU_RECOVER: begin
				if (rec_done) begin
					state_nxt = siu_pkg::SIU_RUN;
				end else if (xtal_tick_in) begin
					cnt_nxt = cnt_r + 13'h0001;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Clock and CPU controls
	// ------------------------------------------------------------
	assign cpu_clk_en_out = state_r == siu_pkg::SIU_RUN;
	assign periph_clk_en_out = state_r == siu_pkg::SIU_RUN ||
		state_r == siu_pkg::SIU_WAIT;
	assign osc_en_out = !(state_r == siu_pkg::SIU_STOP &&
		!stop_oscillator_keep_in);
	assign watchdog_run_out = !watchdog_disable_in &&
		state_r != siu_pkg::SIU_STOP;
	assign clear_imask_out = state_r == siu_pkg::SIU_RUN &&
		(wait_exec_in || stop_exec_in);
	assign reset_active_out = any_reset | rec_reset_r;
	assign irq_take_out = take_r;
	assign vector_sel_out = vec_r;
	assign recovery_count_out = cnt_r;
	assign reg_rdata_out = rdata_r;

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	// Resets outrank everything: no vector is offered while one is
	// active. A reset during stop forces the long recovery.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r     <= siu_pkg::SIU_RUN;
			cnt_r       <= 13'h0000;
			limit_r     <= siu_pkg::LONG_RECOVERY_CYC;
			rec_reset_r <= 1'b0;
		end else if (clk_en_in) begin
			if (any_reset && state_r == siu_pkg::SIU_STOP) begin
				state_r     <= siu_pkg::SIU_RECOVER;
				cnt_r       <= 13'h0000;
				limit_r     <= siu_pkg::LONG_RECOVERY_CYC;
				rec_reset_r <= 1'b1;
			end else begin
				state_r     <= state_nxt;
				cnt_r       <= cnt_nxt;
				limit_r     <= limit_nxt;
				if (state_nxt == siu_pkg::SIU_RUN) begin
					rec_reset_r <= 1'b0;
				end
			end
		end
	end

	// Vector choice is captured once per take: break and the
	// software interrupt share vector one. A take never follows
	// another directly, so the CPU has a cycle to set its mask.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			take_r <= 1'b0;
			vec_r  <= 5'h00;
			brk_r  <= 1'b0;
		end else if (clk_en_in) begin
			take_r <= 1'b0;
			if (any_reset || rec_reset_r) begin
				vec_r <= 5'h00;
				brk_r <= 1'b0;
			end else if (state_nxt == siu_pkg::SIU_RUN &&
				state_r != siu_pkg::SIU_STOP && !take_r) begin
				if (break_req_in || swi_exec_in) begin
					take_r <= 1'b1;
					vec_r  <= 5'h01;
					brk_r  <= break_req_in | brk_r;
				end else if (any_irq) begin
					take_r <= 1'b1;
					vec_r  <= win_idx;
				end
			end
			if (break_done_in) begin
				brk_r <= 1'b0;
			end
		end
	end

	// Software registers and read data.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rsrc_r  <= siu_pkg::RSRC_RESET_VAL;
			break_clear_enable_r  <= 1'b0;
			bexit_r <= 1'b0;
			rdata_r <= siu_pkg::BYTE_ZERO;
		end else if (clk_en_in) begin
			rsrc_r  <= rsrc_nxt;
			bexit_r <= bexit_nxt;
			rdata_r <= reg_read_in ? rd_mux : siu_pkg::BYTE_ZERO;
			if (reg_write_in && sel_bfc) begin
				break_clear_enable_r <= reg_wdata_in[siu_pkg::BREAK_CLEAR_EN_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_STAT_ONE: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(reg_read_in && sel_one && clk_en_in) |=>
		reg_rdata_out[1:0] == 2'b00)
		else $error("status one low bits not zero");
	AST_STAT_THREE: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(reg_read_in && sel_three && clk_en_in) |=>
		reg_rdata_out[7:2] == 6'h00)
		else $error("status three upper bits not zero");
	AST_STAT_TWO: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(reg_read_in && sel_two && clk_en_in) |=>
		reg_rdata_out == $past(irq_req_in[14:7]))
		else $error("status two mismatch");
	AST_CLR_GUARD: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(brk_r && !break_clear_enable_r) |-> !flag_clear_ok_out)
		else $error("flag cleared while protected");
	AST_RSRC_CLR: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(reg_read_in && sel_rsrc && clk_en_in && !any_reset) |=>
		rsrc_r == 8'h00)
		else $error("reset source not cleared by read");
	AST_POR: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(por_event_in && clk_en_in) |=> rsrc_r == siu_pkg::RSRC_RESET_VAL)
		else $error("power-on flag wrong");
	AST_NO_STACK: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		state_r == siu_pkg::SIU_RECOVER |-> !take_r && !cpu_clk_en_out)
		else $error("stacking during recovery");
	AST_LONG_REC: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(any_reset && state_r == siu_pkg::SIU_STOP && clk_en_in) |=>
		limit_r == siu_pkg::LONG_RECOVERY_CYC)
		else $error("reset exit not long recovery");
	AST_STOP_CNT: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(state_r == siu_pkg::SIU_STOP && clk_en_in) |=> cnt_r == 13'h0000)
		else $error("counter not held in stop");
	AST_WAIT_WAKE: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(state_r == siu_pkg::SIU_WAIT && any_irq && !any_reset && clk_en_in)
		|=> take_r)
		else $error("wait wake did not stack next cycle");
	// Back-to-back takes would stack one source twice.
	AST_TAKE_ONCE: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(take_r && clk_en_in) |=> !take_r)
		else $error("take repeated in the next cycle");
	// A reset cause wipes the vector and offers no take.
	AST_RESET_VEC: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(any_reset && clk_en_in) |=> (!take_r && vec_r == 5'h00))
		else $error("vector offered during reset");
	// An interrupt or break wake with the short option set picks the short recovery.
	AST_SHORT_REC: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(state_r == siu_pkg::SIU_STOP && wake && !any_reset &&
		clk_en_in && short_stop_recovery_in) |=>
		limit_r == siu_pkg::SHORT_RECOVERY_CYC)
		else $error("short recovery not selected");
	// Stop without the keep option gates the generator and peripherals.
	AST_OSC_OFF: assert property (
		@(posedge clock_in) disable iff (!rst_n_in)
		(state_r == siu_pkg::SIU_STOP && !stop_oscillator_keep_in) |->
		(!osc_en_out && !periph_clk_en_out))
		else $error("clocks running in stop");
	COV_WAIT: cover property (@(posedge clock_in) state_r == siu_pkg::SIU_WAIT ##1
		take_r);
	COV_STOP: cover property (@(posedge clock_in) state_r == siu_pkg::SIU_RECOVER
		##1 state_r == siu_pkg::SIU_RUN);
	COV_BRK: cover property (@(posedge clock_in) brk_r && flag_clear_ok_out);
	COV_RESET_STOP: cover property (@(posedge clock_in)
		rec_reset_r && state_r == siu_pkg::SIU_RECOVER);
	COV_PRIO: cover property (@(posedge clock_in) take_r && vec_r > 5'h01);

endmodule

// ---- shared/siu_pkg.sv ----
// Package of constants for the system integration unit.
package siu_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [15:0] BREAK_STATUS_OFS     = 16'hFE00;
	localparam logic [15:0] RESET_SOURCE_OFS     = 16'hFE01;
	localparam logic [15:0] BREAK_FLAG_CTRL_OFS  = 16'hFE03;
	localparam logic [15:0] IRQ_STATUS_ONE_OFS   = 16'hFE04;
	localparam logic [15:0] IRQ_STATUS_TWO_OFS   = 16'hFE05;
	localparam logic [15:0] IRQ_STATUS_THREE_OFS = 16'hFE06;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int          BREAK_EXIT_WAIT_BIT  = 1;
	localparam int          BREAK_CLEAR_EN_BIT   = 7;
	localparam int          RSRC_POR_BIT         = 7;
	localparam int          RSRC_PIN_BIT         = 6;
	localparam int          RSRC_WDOG_BIT        = 5;
	localparam int          RSRC_OPC_BIT         = 4;
	localparam int          RSRC_ADR_BIT         = 3;
	localparam int          RSRC_MON_BIT         = 2;
	localparam int          RSRC_LVR_BIT         = 0;
	localparam logic [7:0]  RSRC_RESET_VAL       = 8'h80;
	localparam logic [7:0]  BYTE_ZERO            = 8'h00;
	localparam int          NUM_SOURCES          = 16;

	// ------------------------------------------------------------
	// Recovery counts in crystal-clock cycles
	// ------------------------------------------------------------
	localparam logic [12:0] LONG_RECOVERY_CYC    = 13'h1000;
	localparam logic [12:0] SHORT_RECOVERY_CYC   = 13'h0020;

	// ------------------------------------------------------------
	// Low-power state machine
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SIU_RUN     = 2'b00,
		SIU_WAIT    = 2'b01,
		SIU_STOP    = 2'b10,
		SIU_RECOVER = 2'b11
	} siu_lp_e;

endpackage

// ---- tb/siu_cpu_model.sv ----
// Behavioural CPU core and interrupt sources beside the integration unit.
`timescale 1ns/10ps
module siu_cpu_model (
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	input  wire logic        irq_take_in,
	input  wire logic [4:0]  vector_sel_in,
	input  wire logic        clear_imask_in,
	input  wire logic        unmask_in,
	input  wire logic [16:1] raise_in,
	input  wire logic [16:1] drop_in,
	output logic             imask_out,
	output logic      [16:1] req_out
);
	// Stacking sets the mask; the handler retires the source it served.
	// Requests stay up until served or dropped through drop_in.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			imask_out <= 1'b1;
			req_out   <= 16'h0000;
		end else begin
			if (irq_take_in)
				imask_out <= 1'b1;
			else if (clear_imask_in || unmask_in)
				imask_out <= 1'b0;
			req_out <= (req_out | raise_in) & ~drop_in;
			if (irq_take_in && vector_sel_in > 5'h01)
				req_out[vector_sel_in - 5'h01] <= 1'b0;
		end
	end
endmodule

// ---- tb/test_siu_core.sv ----
// Self-checking testbench for the system integration unit core.
`timescale 1ns/10ps
module test_siu_core;
	localparam logic [16:1] PAT = 16'hA5C3;
	logic        clk, rst_n, wr, rd, clr_req, ssr, wdd, cpu_ce, per_ce, osc;
	logic        clr_ok, rst_act, take, wdr, clim, bst, imask;
	logic        ce, xt, xslow, keep;
	logic [15:0] addr;
	logic [7:0]  wdata, rdata, d;
	logic [16:1] en, raise, drop, req, p;
	logic [13:0] ev;
	logic [4:0]  vec;
	logic [12:0] rcnt;
	int          n_mismatch, cmp_count, n, b, k, cyc;

	// Bench clock at 25 MHz.
	always #20 clk = ~clk;

	// Crystal tick: every cycle, or every other cycle while xslow is set.
	always @(posedge clk) xt <= xslow ? ~xt : 1'b1;

	siu_cpu_model i_cpu (.clock_in(clk), .rst_n_in(rst_n),
		.irq_take_in(take), .vector_sel_in(vec), .clear_imask_in(clim),
		.unmask_in(ev[13]), .raise_in(raise), .drop_in(drop),
		.imask_out(imask), .req_out(req));

	// Tick, enable and keep option are bench signals, so counting
	// ticks rather than clocks and freezing can both be seen.
	siu_core i_dut (.clock_in(clk), .rst_n_in(rst_n), .clk_en_in(ce),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
		.reg_read_in(rd), .reg_rdata_out(rdata), .irq_req_in(req),
		.irq_enable_in(en), .cpu_imask_in(imask), .swi_exec_in(ev[8]),
		.break_req_in(ev[9]), .break_done_in(ev[10]),
		.wait_exec_in(ev[11]), .stop_exec_in(ev[12]), .xtal_tick_in(xt),
		.short_stop_recovery_in(ssr), .stop_oscillator_keep_in(keep),
		.watchdog_disable_in(wdd), .por_event_in(ev[7]),
		.pin_reset_in(ev[6]), .watchdog_reset_in(ev[5]),
		.bad_opcode_in(ev[4]), .bad_fetch_address_in(ev[3]),
		.forced_monitor_in(ev[2]), .low_voltage_in(ev[0]),
		.flag_clear_req_in(clr_req), .flag_clear_ok_out(clr_ok),
		.reset_active_out(rst_act), .irq_take_out(take),
		.vector_sel_out(vec), .cpu_clk_en_out(cpu_ce),
		.periph_clk_en_out(per_ce), .osc_en_out(osc),
		.watchdog_run_out(wdr), .clear_imask_out(clim),
		.break_state_out(bst), .recovery_count_out(rcnt));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic settle();
		@(posedge clk);
		#1;
	endtask

	task automatic reg_wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic reg_rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
	endtask

	// The wait is bounded so a missing answer cannot hang the run.
	task automatic wait_take(output int c);
		c = 0;
		#1;
		while (take !== 1'b1 && c < 5000) begin
			settle();
			c++;
		end
		if (take !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] take expected 1 seen %b", take);
		end
	endtask

	task automatic take_vec(input logic [4:0] e);
		wait_take(n);
		chk("vector", e, vec);
	endtask

	task automatic complete_run();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Watchdog sized well above the two long recoveries.
	initial begin
		#2000000;
		n_mismatch++;
		complete_run();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 16'h0000;
		wdata = 8'h00; en = 16'hFFFF; raise = 16'h0000; drop = 16'h0000;
		ev = 14'h0000; clr_req = 1'b0; ssr = 1'b0; wdd = 1'b0;
		ce = 1'b1;
		xt = 1'b1;
		xslow = 1'b0;
		keep = 1'b0;
		n_mismatch = 0; cmp_count = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		reg_rd(siu_pkg::RESET_SOURCE_OFS, d);
		chk("rsrc_por", 8'h80, d);
		reg_rd(siu_pkg::RESET_SOURCE_OFS, d);
		chk("rsrc_clr", 8'h00, d);
		for (b = 0; b < 7; b++) if (b != 1) begin
			pulse(b);
			reg_rd(siu_pkg::RESET_SOURCE_OFS, d);
			chk("rsrc_one", 8'h01 << b, d);
		end
		pulse(6);
		pulse(5);
		reg_rd(siu_pkg::RESET_SOURCE_OFS, d);
		chk("rsrc_two", 8'h60, d);
		pulse(0);
		pulse(7);
		// A read while the enable is low is not taken and clears nothing.
		ce <= 1'b0;
		reg_rd(siu_pkg::RESET_SOURCE_OFS, d);
		chk("rsrc_frozen", 8'h00, d);
		@(posedge clk);
		ce <= 1'b1;
		reg_rd(siu_pkg::RESET_SOURCE_OFS, d);
		chk("rsrc_por2", 8'h80, d);
		// Live flags for a pattern and its inverse, mask held by the CPU.
		for (k = 0; k < 2; k++) begin
			p = (k == 0) ? PAT : ~PAT;
			@(posedge clk);
			raise <= p;
			drop  <= ~p;
			@(posedge clk);
			raise <= 16'h0000;
			drop  <= 16'h0000;
			reg_wr(siu_pkg::IRQ_STATUS_ONE_OFS, 8'hFF);
			reg_rd(siu_pkg::IRQ_STATUS_ONE_OFS, d);
			chk("status_one", {p[6:1], 2'b00}, d);
			reg_rd(siu_pkg::IRQ_STATUS_TWO_OFS, d);
			chk("status_two", p[14:7], d);
			reg_rd(siu_pkg::IRQ_STATUS_THREE_OFS, d);
			chk("status_three", {6'h00, p[16:15]}, d);
			reg_rd(siu_pkg::IRQ_STATUS_TWO_OFS, d);
			chk("status_again", p[14:7], d);
		end
		reg_rd(16'hFE02, d);
		chk("unmapped", 8'h00, d);
		// Priority: software interrupt ignores the mask, then sources.
		@(posedge clk);
		drop  <= 16'hFFFF;
		@(posedge clk);
		drop  <= 16'h0000;
		raise <= 16'h0104;
		en    <= ~16'h0004;
		@(posedge clk);
		raise <= 16'h0000;
		pulse(8);
		take_vec(5'h01);
		pulse(13);
		take_vec(5'h0A);
		@(posedge clk);
		en <= 16'hFFFF;
		pulse(13);
		take_vec(5'h04);
		// Break state and flag protection.
		pulse(9);
		take_vec(5'h01);
		@(posedge clk);
		clr_req <= 1'b1;
		settle();
		chk("break_state", 1'b1, bst);
		chk("clear_blocked", 1'b0, clr_ok);
		reg_wr(siu_pkg::BREAK_FLAG_CTRL_OFS, 8'h80);
		settle();
		chk("clear_allowed", 1'b1, clr_ok);
		reg_rd(siu_pkg::BREAK_FLAG_CTRL_OFS, d);
		chk("flag_ctrl", 8'h80, d);
		pulse(10);
		settle();
		chk("break_end", 1'b0, bst);
		@(posedge clk);
		clr_req <= 1'b0;
		reg_wr(siu_pkg::BREAK_FLAG_CTRL_OFS, 8'h00);
		// Wait mode, left by a break.
		pulse(11);
		settle();
		chk("wait_cpu", 1'b0, cpu_ce);
		chk("wait_periph", 1'b1, per_ce);
		chk("wait_wdog", 1'b1, wdr);
		chk("wait_mask", 1'b0, imask);
		@(posedge clk);
		wdd <= 1'b1;
		settle();
		chk("wait_wdog_off", 1'b0, wdr);
		@(posedge clk);
		wdd <= 1'b0;
		pulse(9);
		take_vec(5'h01);
		reg_rd(siu_pkg::BREAK_STATUS_OFS, d);
		chk("break_exit_wait", 1'b1, d[1]);
		pulse(10);
		// Stop with short then long recovery, woken by source 16.
		// The short run ticks every other cycle: 32 ticks, 64 cycles.
		// The long run keeps the oscillator, the short one does not.
		for (k = 0; k < 2; k++) begin
			cyc = (k == 0) ? 64 : 4096;
			@(posedge clk);
			ssr   <= (k == 0);
			xslow <= (k == 0);
			keep  <= (k == 1);
			pulse(12);
			settle();
			chk("stop_cpu", 1'b0, cpu_ce);
			chk("stop_periph", 1'b0, per_ce);
			chk("stop_osc", k, osc);
			chk("stop_count", 13'h0000, rcnt);
			chk("stop_mask", 1'b0, imask);
			@(posedge clk);
			raise <= 16'h8000;
			@(posedge clk);
			raise <= 16'h0000;
			wait_take(n);
			chk("rec_min", 1'b1, n >= cyc);
			chk("rec_max", 1'b1, n <= cyc + 10);
			chk("rec_vec", 5'h11, vec);
		end
		// A reset ends stop: long recovery despite the short setting.
		@(posedge clk);
		ssr <= 1'b1;
		pulse(12);
		pulse(6);
		n = 0;
		while (rst_act === 1'b1 && n < 5000) begin
			settle();
			n++;
		end
		chk("reset_rec_min", 1'b1, n >= 4090);
		chk("reset_rec_max", 1'b1, n <= 4110);
		complete_run();
	end
endmodule
